// ### rtl/param_loader_pkg.sv
// Package of word addresses, field positions, reset values and timing for the parameter loader.
package param_loader_pkg;

    localparam int NUM_PORTS = 6;
    localparam int WORD_W = 16;
    localparam int ADDR_W = 8;

    // ------------------------------------------------------------
    // Memory word addresses
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] PM_WORD_BASE_ADDR = 8'h80;
    localparam logic [ADDR_W-1:0] PM_WORD_STEP = 8'h02;
    localparam logic [ADDR_W-1:0] SLOT_CAP_LO_P1_ADDR = 8'h92;

    // ------------------------------------------------------------
    // Source bit positions in the parameter word
    // ------------------------------------------------------------
    localparam int SRC_D3_L1_LSB = 0;
    localparam int SRC_L1_DLY_LSB = 2;
    localparam int SRC_L0S_LSB = 4;
    localparam int SRC_RX_POL_DIS = 6;
    localparam int SRC_VGA_EN = 7;
    localparam int SRC_PHY_LSB = 8;

    // ------------------------------------------------------------
    // Configuration offsets and destination field positions
    // ------------------------------------------------------------
    localparam logic [7:0] CFG_VGA_OFFSET = 8'h70;
    localparam logic [7:0] CFG_PM_OFFSET = 8'h74;
    localparam logic [7:0] CFG_PHY_OFFSET = 8'h88;
    localparam logic [7:0] CFG_SLOT_CAP_OFFSET = 8'hd4;
    localparam int DST_PM_LSB = 8;
    localparam int DST_RX_POL_DIS = 14;
    localparam int DST_VGA_EN = 31;
    localparam int DST_PHY_LSB = 24;
    localparam int SLOT_CAP_PORT = 1;

    // ------------------------------------------------------------
    // Default field values when no word is loaded
    // ------------------------------------------------------------
    localparam logic [5:0] PM_FIELD_RST = 6'h00;
    localparam logic RX_POL_DIS_RST = 1'b0;
    localparam logic VGA_EN_RST = 1'b0;
    localparam logic [7:0] PHY_BYTE_RST = 8'h00;
    localparam logic [15:0] SLOT_CAP_LO_RST = 16'h0000;

    // ------------------------------------------------------------
    // Sequencing
    // ------------------------------------------------------------
    localparam logic [2:0] LAST_PM_IDX = 3'h5;
    localparam logic [3:0] RD_TIMEOUT_CYC = 4'hf;

endpackage : param_loader_pkg

// ### rtl/param_field_if.sv
// Interface carrying one decoded word between the sequencer and the field store.
`timescale 1ns/10ps
interface param_field_if;
    import param_loader_pkg::*;

    logic pm_wr;
    logic slot_wr;
    logic [2:0] port_idx;
    logic [WORD_W-1:0] word;

    modport src
    (
        output pm_wr,
        output slot_wr,
        output port_idx,
        output word
    );

    modport dst
    (
        input pm_wr,
        input slot_wr,
        input port_idx,
        input word
    );
endinterface : param_field_if

// ### rtl/param_field_store.sv
// Field store that scatters loaded words into per-port configuration fields.
`timescale 1ns/10ps
module param_field_store
(
    input wire logic core_clk_i,
    input wire logic nrst_i,
    param_field_if.dst fld,
    output logic [param_loader_pkg::NUM_PORTS*6-1:0] pm_field_o,
    output logic [param_loader_pkg::NUM_PORTS-1:0] rx_pol_dis_o,
    output logic [param_loader_pkg::NUM_PORTS-1:0] vga_decode_en_o,
    output logic [param_loader_pkg::NUM_PORTS*8-1:0] phy_ctrl_status_word5_o,
    output logic [15:0] slot_cap_lo_o
);
    import param_loader_pkg::*;

    typedef struct packed {
        logic [NUM_PORTS*6-1:0] pm;
        logic [NUM_PORTS-1:0] rx_pol;
        logic [NUM_PORTS-1:0] vga;
        logic [NUM_PORTS*8-1:0] phy;
        logic [15:0] slot;
    } store_s;

    store_s st_reg;
    store_s st_next;

    // ------------------------------------------------------------
    // Word scatter
    // ------------------------------------------------------------
    always_comb
    begin
        st_next = st_reg;
        for (int p = 0; p < NUM_PORTS; p++)
        begin
            if (fld.pm_wr && fld.port_idx == p[2:0])
            begin
                st_next.pm[p*6 +: 6] = fld.word[SRC_D3_L1_LSB +: 6];
                st_next.rx_pol[p] = fld.word[SRC_RX_POL_DIS];
                st_next.vga[p] = fld.word[SRC_VGA_EN];
                st_next.phy[p*8 +: 8] = fld.word[SRC_PHY_LSB +: 8];
            end
        end
        if (fld.slot_wr)
        begin
            st_next.slot = fld.word;
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            // Fields never written keep these defaults.
            st_reg.pm <= {NUM_PORTS{PM_FIELD_RST}};
            st_reg.rx_pol <= {NUM_PORTS{RX_POL_DIS_RST}};
            st_reg.vga <= {NUM_PORTS{VGA_EN_RST}};
            st_reg.phy <= {NUM_PORTS{PHY_BYTE_RST}};
            st_reg.slot <= SLOT_CAP_LO_RST;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign pm_field_o = st_reg.pm;
    assign rx_pol_dis_o = st_reg.rx_pol;
    assign vga_decode_en_o = st_reg.vga;
    assign phy_ctrl_status_word5_o = st_reg.phy;
    assign slot_cap_lo_o = st_reg.slot;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_rx_pol_copy: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        fld.pm_wr |=> rx_pol_dis_o[$past(fld.port_idx)] == $past(fld.word[SRC_RX_POL_DIS]))
        else $error("Receive polarity bit not loaded.");

    a_vga_copy: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        fld.pm_wr |=> vga_decode_en_o[$past(fld.port_idx)] == $past(fld.word[SRC_VGA_EN]))
        else $error("Legacy decode enable not loaded.");

    a_pm_field_copy: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        fld.pm_wr && fld.port_idx == 3'h0 |=> pm_field_o[5:0] == $past(fld.word[5:0]))
        else $error("Power management field of port 0 wrong.");

    a_phy_byte_copy: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        fld.pm_wr && fld.port_idx == 3'h5
        |=> phy_ctrl_status_word5_o[47:40] == $past(fld.word[15:8]))
        else $error("Physical layer byte of port 5 wrong.");

    a_slot_copy: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        fld.slot_wr |=> slot_cap_lo_o == $past(fld.word))
        else $error("Slot capability low word not loaded.");

    a_idle_hold: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        !fld.pm_wr && !fld.slot_wr |=> $stable(pm_field_o) && $stable(slot_cap_lo_o))
        else $error("Field changed without a load.");

endmodule : param_field_store

// ### rtl/eeprom_port_param_loader.sv
// Top of the loader that fetches parameter words and scatters them into port fields.
`timescale 1ns/10ps
module eeprom_port_param_loader
(
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic start_i,
    output logic mem_rd_req_o,
    output logic [param_loader_pkg::ADDR_W-1:0] mem_rd_addr_o,
    input wire logic mem_rd_valid_i,
    input wire logic [param_loader_pkg::WORD_W-1:0] mem_rd_data_i,
    input wire logic mem_absent_i,
    output logic load_done_o,
    output logic cfg_ready_o,
    output logic [param_loader_pkg::NUM_PORTS*6-1:0] pm_field_o,
    output logic [param_loader_pkg::NUM_PORTS-1:0] rx_pol_dis_o,
    output logic [param_loader_pkg::NUM_PORTS-1:0] vga_decode_en_o,
    output logic [param_loader_pkg::NUM_PORTS*8-1:0] phy_ctrl_status_word5_o,
    output logic [15:0] slot_cap_lo_o
);
    import param_loader_pkg::*;

    typedef enum logic [1:0]
    {
        ST_IDLE = 2'b00,
        ST_REQ = 2'b01,
        ST_WAIT = 2'b10,
        ST_DONE = 2'b11
    } loader_state_e;

    typedef struct packed {
        loader_state_e state;
        logic [2:0] idx;
        logic [3:0] tmo;
        logic [ADDR_W-1:0] addr;
        logic pm_wr;
        logic slot_wr;
        logic [2:0] port_idx;
        logic [WORD_W-1:0] word;
    } seq_s;

    seq_s s_reg;
    seq_s s_next;

    param_field_if fld ();

    // ------------------------------------------------------------
    // Address of the n-th word in the load sequence
    // ------------------------------------------------------------
    function automatic logic [ADDR_W-1:0] word_addr(input logic [2:0] n);
        logic [ADDR_W-1:0] a;
        if (n > LAST_PM_IDX)
            a = SLOT_CAP_LO_P1_ADDR;
        else
            a = PM_WORD_BASE_ADDR + ADDR_W'(n) * PM_WORD_STEP;
        return a;
    endfunction : word_addr

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb
    begin
        s_next = s_reg;
        s_next.pm_wr = 1'b0;
        s_next.slot_wr = 1'b0;
        unique case (s_reg.state)
            ST_IDLE:
            begin
                if (start_i)
                begin
                    // A missing memory leaves every field at its default.
                    if (mem_absent_i)
                        s_next.state = ST_DONE;
                    else
                    begin
                        s_next.state = ST_REQ;
                        s_next.idx = 3'h0;
                        s_next.addr = word_addr(3'h0);
                    end
                end
            end
            ST_REQ:
            begin
                s_next.state = ST_WAIT;
                s_next.tmo = RD_TIMEOUT_CYC;
            end
            ST_WAIT:
            begin
                // A word that never arrives is skipped so the load cannot hang.
                if (mem_rd_valid_i || s_reg.tmo == 4'h0)
                begin
                    if (mem_rd_valid_i)
                    begin
                        s_next.word = mem_rd_data_i;
                        s_next.port_idx = s_reg.idx;
                        s_next.pm_wr = (s_reg.idx <= LAST_PM_IDX);
                        s_next.slot_wr = (s_reg.idx > LAST_PM_IDX);
                    end
                    if (s_reg.idx > LAST_PM_IDX)
                        s_next.state = ST_DONE;
                    else
                    begin
                        s_next.idx = s_reg.idx + 3'h1;
                        s_next.addr = word_addr(s_reg.idx + 3'h1);
                        s_next.state = ST_REQ;
                    end
                end
                else
                    s_next.tmo = s_reg.tmo - 4'h1;
            end
            ST_DONE:
            begin
                s_next.state = ST_DONE;
            end
        endcase
    end

    always_ff @(posedge core_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            s_reg <= '{state: ST_IDLE, idx: 3'h0, tmo: 4'h0, addr: 8'h00, pm_wr: 1'b0,
                       slot_wr: 1'b0, port_idx: 3'h0, word: 16'h0000};
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign fld.pm_wr = s_reg.pm_wr;
    assign fld.slot_wr = s_reg.slot_wr;
    assign fld.port_idx = s_reg.port_idx;
    assign fld.word = s_reg.word;

    assign mem_rd_req_o = (s_reg.state == ST_REQ);
    assign mem_rd_addr_o = s_reg.addr;
    assign load_done_o = (s_reg.state == ST_DONE);
    // The last word is written one cycle after entering done, so hold ready one more cycle.
    assign cfg_ready_o = load_done_o && !s_reg.pm_wr && !s_reg.slot_wr;

    param_field_store param_field_store_inst
    (
        .core_clk_i(core_clk_i),
        .nrst_i(nrst_i),
        .fld(fld),
        .pm_field_o(pm_field_o),
        .rx_pol_dis_o(rx_pol_dis_o),
        .vga_decode_en_o(vga_decode_en_o),
        .phy_ctrl_status_word5_o(phy_ctrl_status_word5_o),
        .slot_cap_lo_o(slot_cap_lo_o)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_pm_addr_map: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        mem_rd_req_o && s_reg.idx <= LAST_PM_IDX
        |-> mem_rd_addr_o == 8'h80 + {4'h0, s_reg.idx, 1'b0})
        else $error("Parameter word address wrong.");

    a_slot_addr_map: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        mem_rd_req_o && s_reg.idx > LAST_PM_IDX |-> mem_rd_addr_o == 8'h92)
        else $error("Slot capability word address wrong.");

    a_ready_after_load: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        cfg_ready_o |-> !mem_rd_req_o && s_reg.state == ST_DONE ##1 cfg_ready_o)
        else $error("Configuration ready before load ends.");

    a_req_one_cycle: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        mem_rd_req_o |=> !mem_rd_req_o)
        else $error("Read request held longer than one cycle.");

    a_wait_bounded: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        mem_rd_req_o |=> s_reg.state == ST_WAIT ##[1:16] s_reg.state != ST_WAIT)
        else $error("Read wait not ended by the timeout.");

    a_word_capture: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        s_reg.state == ST_WAIT && mem_rd_valid_i
        |=> fld.word == $past(mem_rd_data_i) && (fld.pm_wr != fld.slot_wr))
        else $error("Returned word not passed to the field store.");

    a_skip_silent: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        s_reg.state == ST_WAIT && s_reg.tmo == 4'h0 && !mem_rd_valid_i
        |=> !fld.pm_wr && !fld.slot_wr)
        else $error("Timed out word written to a field.");

    a_absent_skip: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        s_reg.state == ST_IDLE && start_i && mem_absent_i |=> load_done_o && !mem_rd_req_o)
        else $error("Absent memory did not skip the load.");

    a_done_sticky: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        load_done_o |=> load_done_o && !mem_rd_req_o)
        else $error("Load restarted after completion.");

    // ------------------------------------------------------------
    // Per-port checks
    // ------------------------------------------------------------
    // Every port is checked, since a slicing slip often hits only the middle ports.
    for (genvar p = 0; p < NUM_PORTS; p++)
    begin : g_port_chk
        a_port_pm_copy: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
            fld.pm_wr && fld.port_idx == 3'(p)
            |=> pm_field_o[p*6 +: 6] == $past(fld.word[SRC_D3_L1_LSB +: 6]))
            else $error("Power management field not loaded.");

        a_port_phy_copy: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
            fld.pm_wr && fld.port_idx == 3'(p)
            |=> phy_ctrl_status_word5_o[p*8 +: 8] == $past(fld.word[SRC_PHY_LSB +: 8]))
            else $error("Physical layer byte not loaded.");

        a_port_untouched: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
            !(fld.pm_wr && fld.port_idx == 3'(p))
            |=> $stable(pm_field_o[p*6 +: 6]) && $stable(phy_ctrl_status_word5_o[p*8 +: 8])
                && $stable(rx_pol_dis_o[p]) && $stable(vga_decode_en_o[p]))
            else $error("Port field changed without its own word.");
    end

endmodule : eeprom_port_param_loader

// ### testbench/param_mem_model.sv
// Behavioural configuration memory that answers word reads after a chosen delay.
`timescale 1ns/10ps
module param_mem_model
(
    input wire logic core_clk_i,
    input wire logic rd_req_i,
    input wire logic [7:0] rd_addr_i,
    input wire logic [3:0] delay_i,
    input wire logic [7:0] drop_addr_i,
    output logic rd_valid_o,
    output logic [15:0] rd_data_o
);
    logic [15:0] mem [0:255];

    initial
    begin
        rd_valid_o = 1'b0;
        rd_data_o = 16'h5a5a;
    end

    // The data lines toggle while no read is pending, and hold during a read's delay, so that stale words are never reused.
    always @(posedge core_clk_i)
    begin
        if (rd_req_i === 1'b1 && rd_addr_i !== drop_addr_i)
        begin
            repeat (delay_i) @(posedge core_clk_i);
            rd_valid_o <= 1'b1;
            rd_data_o <= mem[rd_addr_i];
            @(posedge core_clk_i);
            rd_valid_o <= 1'b0;
            rd_data_o <= ~mem[rd_addr_i];
        end
        else
            rd_data_o <= ~rd_data_o;
    end
endmodule : param_mem_model

// ### testbench/test_eeprom_port_param_loader.sv
// Self-checking testbench for the port parameter loader.
`timescale 1ns/10ps
module test_eeprom_port_param_loader;
    import param_loader_pkg::*;

    logic core_clk_i;
    logic nrst_i;
    logic start_i;
    logic mem_absent_i;
    logic mem_rd_req_o;
    logic [ADDR_W-1:0] mem_rd_addr_o;
    logic mem_rd_valid_i;
    logic [WORD_W-1:0] mem_rd_data_i;
    logic load_done_o;
    logic cfg_ready_o;
    logic [NUM_PORTS*6-1:0] pm_field_o;
    logic [NUM_PORTS-1:0] rx_pol_dis_o;
    logic [NUM_PORTS-1:0] vga_decode_en_o;
    logic [NUM_PORTS*8-1:0] phy_ctrl_status_word5_o;
    logic [15:0] slot_cap_lo_o;
    logic [3:0] mem_delay;
    logic [7:0] mem_drop;
    logic [7:0] addr_q[$];
    logic [111:0] fld_q[$];
    logic ready_seen;
    logic hung;
    logic [111:0] fields_seen;
    logic [1:0] flags_seen;

    assign fields_seen = {slot_cap_lo_o, phy_ctrl_status_word5_o,
        vga_decode_en_o, rx_pol_dis_o, pm_field_o};
    assign flags_seen = {load_done_o, cfg_ready_o};
    int err_total;
    int tests_run;

    eeprom_port_param_loader eeprom_port_param_loader_inst
    (
        .core_clk_i(core_clk_i),
        .nrst_i(nrst_i),
        .start_i(start_i),
        .mem_rd_req_o(mem_rd_req_o),
        .mem_rd_addr_o(mem_rd_addr_o),
        .mem_rd_valid_i(mem_rd_valid_i),
        .mem_rd_data_i(mem_rd_data_i),
        .mem_absent_i(mem_absent_i),
        .load_done_o(load_done_o),
        .cfg_ready_o(cfg_ready_o),
        .pm_field_o(pm_field_o),
        .rx_pol_dis_o(rx_pol_dis_o),
        .vga_decode_en_o(vga_decode_en_o),
        .phy_ctrl_status_word5_o(phy_ctrl_status_word5_o),
        .slot_cap_lo_o(slot_cap_lo_o)
    );

    param_mem_model param_mem_model_inst
    (
        .core_clk_i(core_clk_i),
        .rd_req_i(mem_rd_req_o),
        .rd_addr_i(mem_rd_addr_o),
        .delay_i(mem_delay),
        .drop_addr_i(mem_drop),
        .rd_valid_o(mem_rd_valid_i),
        .rd_data_o(mem_rd_data_i)
    );

    initial
    begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end

    // ------------------------------------------------------------
    // Compare and closing tasks
    // ------------------------------------------------------------
    task automatic cmp_addr(input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp)
        begin
            err_total++;
            $display("Error mem_rd_addr_o expected %h seen %h", exp, got);
        end
    endtask : cmp_addr

    task automatic cmp_fields(input logic [111:0] exp, input logic [111:0] got);
        tests_run++;
        if (got !== exp)
        begin
            err_total++;
            $display("Error port fields expected %h seen %h", exp, got);
        end
    endtask : cmp_fields

    task automatic cmp_flags(input logic [1:0] exp, input logic [1:0] got);
        tests_run++;
        if (got !== exp)
        begin
            err_total++;
            $display("Error done and ready flags expected %b seen %b", exp, got);
        end
    endtask : cmp_flags

    task automatic stop_test;
        $display("Comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : stop_test

    // ------------------------------------------------------------
    // Output watcher
    // ------------------------------------------------------------
    // Any read request with no note pending is compared against an address never used.
    always @(posedge core_clk_i)
    begin
        if (nrst_i === 1'b1 && mem_rd_req_o === 1'b1)
            cmp_addr((addr_q.size() > 0) ? addr_q.pop_front() : 8'hff, mem_rd_addr_o);
        if (nrst_i === 1'b1 && cfg_ready_o === 1'b1 && !ready_seen && fld_q.size() > 0)
        begin
            ready_seen = 1'b1;
            cmp_fields(fld_q.pop_front(), fields_seen);
            cmp_flags(2'b11, flags_seen);
        end
    end

    // ------------------------------------------------------------
    // Driver tasks
    // ------------------------------------------------------------
    task automatic do_reset;
        nrst_i <= 1'b0;
        repeat (4) @(posedge core_clk_i);
        addr_q.delete();
        fld_q.delete();
        ready_seen = 1'b0;
        cmp_fields(112'h0, fields_seen);
        cmp_flags(2'b00, flags_seen);
        nrst_i <= 1'b1;
    endtask : do_reset

    task automatic run_load(input logic absent, input logic [3:0] dly, input logic [7:0] drop,
        input logic ones, input logic cut);
        logic [111:0] exp;
        logic [15:0] w;
        logic [7:0] a;
        int n;
        if (hung)
            return;
        exp = '0;
        mem_delay <= dly;
        mem_drop <= drop;
        for (int k = 0; k < 7; k++)
        begin
            a = (k < 6) ? 8'(PM_WORD_BASE_ADDR + PM_WORD_STEP * k) : SLOT_CAP_LO_P1_ADDR;
            w = ones ? 16'hffff : 16'($urandom);
            param_mem_model_inst.mem[a] = w;
            if (!absent)
                addr_q.push_back(a);
            if (absent || a == drop)
                w = '0;
            if (k < 6)
            begin
                exp[k*6+:6] = w[5:0];
                exp[36+k] = w[6];
                exp[42+k] = w[7];
                exp[48+k*8+:8] = w[15:8];
            end
            else
                exp[111:96] = w;
        end
        fld_q.push_back(exp);
        mem_absent_i <= absent;
        start_i <= 1'b1;
        @(posedge core_clk_i);
        start_i <= 1'b0;
        // A cut load is reset part way; the next reset check proves the fields clear.
        if (cut)
            repeat (20) @(posedge core_clk_i);
        else
        begin
            n = 0;
            while (cfg_ready_o !== 1'b1 && n < 400)
            begin
                @(posedge core_clk_i);
                n++;
            end
            if (n == 400)
            begin
                err_total++;
                hung = 1'b1;
            end
            // A second start after completion must not fetch anything.
            start_i <= 1'b1;
            repeat (20) @(posedge core_clk_i);
            start_i <= 1'b0;
        end
    endtask : run_load

    initial
    begin
        nrst_i = 1'b0;
        start_i = 1'b0;
        mem_absent_i = 1'b0;
        mem_delay = 4'h0;
        mem_drop = 8'h00;
        err_total = 0;
        tests_run = 0;
        hung = 1'b0;
        ready_seen = 1'b0;
        void'($urandom(32'h7356));
        do_reset();
        run_load(1'b0, 4'h0, 8'h00, 1'b0, 1'b0);
        do_reset();
        run_load(1'b0, 4'h5, 8'h84, 1'b1, 1'b0);
        do_reset();
        run_load(1'b0, 4'h0, 8'h92, 1'b0, 1'b0);
        do_reset();
        run_load(1'b0, 4'h3, 8'h00, 1'b0, 1'b1);
        do_reset();
        run_load(1'b0, 4'h1, 8'h00, 1'b0, 1'b0);
        do_reset();
        run_load(1'b1, 4'h0, 8'h00, 1'b1, 1'b0);
        stop_test();
    end
endmodule : test_eeprom_port_param_loader
